// ===== design/jdhc_core.v
// jtag debug host: configuration registers, scan engine and sideband
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`include "jdhc_defs.vh"
module jdhc_core #(
	parameter POLL_CYCLES = 16'h1000
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [5:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [5:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	output wire        tck,
	output wire        tms,
	output wire        tdi,
	input  wire        tdo,
	output wire        debug_state_request,
	output wire        debug_state_request_oe,
	input  wire        debug_ack,
	input  wire        break_in,
	output wire        trigger_out,
	output wire        comms_poll_tick,
	output wire [31:0] mem_wdata,
	input  wire [31:0] mem_rdata,
	output wire [31:0] scratch_base,
	output wire [31:0] scratch_last,
	output wire [5:0]  op_phase,
	output wire        nv_save,
	output wire [3:0]  nv_save_data,
	input  wire [3:0]  nv_load_data
);
	// one-hot access phases
	localparam P_IDLE = 6'h01;
	localparam P_HALT = 6'h02;
	localparam P_SAVE = 6'h04;
	localparam P_ACC  = 6'h08;
	localparam P_REST = 6'h10;
	localparam P_RES  = 6'h20;

	reg        aw_ff, w_ff, b_ff, r_ff, berr_ff, rerr_ff;
	reg [5:0]  awa_ff;
	reg [31:0] wd_ff, rd_ff;
	reg [3:0]  ws_ff;
	reg [11:0] ctrl_ff;
	reg [15:0] khz_ff;
	reg [7:0]  half_ff, calc_ff, cnt_ff;
	reg        calc_busy_ff;
	reg [31:0] tms_ff, tdi_ff, tdo_ff, memw_ff, cpa_ff;
	reg [5:0]  len_ff, bit_ff;
	reg        busy_ff, tck_ff;
	reg [5:0]  ph_ff, nxt_ph;
	reg        cp_ff, resume_ff, halted_ff, rj_ff, req_ff, nvs_ff;
	reg [15:0] poll_ff;
	reg        poll_tick_ff;
	reg [31:0] rdv;
	reg        rdok;

	// merge write data into a register by byte strobes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] d;
		input [3:0]  s;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1)
				merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	// byte reversal for big-endian targets
	function [31:0] swap;
		input [31:0] d;
		begin
			swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
		end
	endfunction

	wire do_wr = aw_ff & w_ff & ~b_ff;
	wire [31:0] wv = merge(32'h0, wd_ff, ws_ff);
	wire wr_ctrl = do_wr & (awa_ff == `JDHC_A_CTRL);
	wire wr_spd = do_wr & (awa_ff == `JDHC_A_SPEED);
	wire wr_shf = do_wr & (awa_ff == `JDHC_A_SHIFT);
	wire wr_stat = do_wr & (awa_ff == `JDHC_A_STAT);
	wire wr_op = do_wr & (awa_ff == `JDHC_A_OP);
	wire wr_nv = do_wr & (awa_ff == `JDHC_A_NVCMD);
	wire ack_on = ctrl_ff[`JDHC_C_ACK];
	wire req_on = ctrl_ff[`JDHC_C_REQ];
	wire ack_s = ack_on & debug_ack;
	wire halted = ack_on ? ack_s : halted_ff;
	wire running = ~halted;
	wire op_go = wr_op & ~wv[`JDHC_OP_DONE] & (ph_ff == P_IDLE);
	wire op_adv = wr_op & wv[`JDHC_OP_DONE];
	wire [2:0] opc = wv[2:0];
	wire halting_op = opc >= `JDHC_OP_MEM;
	wire reject = op_go & halting_op & running & ctrl_ff[`JDHC_C_RRT];
	wire [15:0] lim = ctrl_ff[`JDHC_C_LATE] ? `JDHC_KHZ_LATE : `JDHC_KHZ_STD;
	wire [15:0] req_khz = (wv[15:0] < `JDHC_KHZ_MIN) ? `JDHC_KHZ_MIN :
		(wv[15:0] > lim) ? lim : wv[15:0];
	wire [24:0] prod = {calc_ff, 1'b0} * khz_ff;
	wire tick = busy_ff & (cnt_ff == half_ff - 8'h01);

	// axi4-lite write channels, taken in either order
	assign s_axi_awready = ~aw_ff;
	assign s_axi_wready = ~w_ff;
	assign s_axi_bvalid = b_ff;
	assign s_axi_bresp = berr_ff ? `JDHC_RESP_ERR : `JDHC_RESP_OK;
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			b_ff <= 1'b0;
			berr_ff <= 1'b0;
			awa_ff <= 6'h00;
			wd_ff <= 32'h0;
			ws_ff <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_ff) begin
				aw_ff <= 1'b1;
				awa_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_ff) begin
				w_ff <= 1'b1;
				wd_ff <= s_axi_wdata;
				ws_ff <= s_axi_wstrb;
			end
			if (do_wr) begin
				b_ff <= 1'b1;
				berr_ff <= awa_ff > `JDHC_A_NVCMD || awa_ff == `JDHC_A_TDO ||
					awa_ff == `JDHC_A_MEMR || awa_ff[1:0] != 2'h0;
			end
			if (b_ff && s_axi_bready) begin
				b_ff <= 1'b0;
				aw_ff <= 1'b0;
				w_ff <= 1'b0;
			end
		end
	end

	// read mux
	always @* begin
		rdv = 32'h0;
		rdok = 1'b1;
		case (s_axi_araddr)
		`JDHC_A_CTRL:   rdv = {20'h0, ctrl_ff};
		`JDHC_A_SPEED:  rdv = {calc_ff, half_ff, khz_ff};
		`JDHC_A_TMS:    rdv = tms_ff;
		`JDHC_A_TDI:    rdv = tdi_ff;
		`JDHC_A_SHIFT:  rdv = {26'h0, len_ff};
		`JDHC_A_TDO:    rdv = tdo_ff;
		`JDHC_A_STAT:   rdv = {15'h0, req_ff, 2'h0, ph_ff, 3'h0,
			ph_ff != P_IDLE, rj_ff, halted, calc_busy_ff, busy_ff};
		`JDHC_A_OP:     rdv = {26'h0, ph_ff};
		`JDHC_A_MEMW:   rdv = memw_ff;
		`JDHC_A_MEMR:   rdv = ctrl_ff[`JDHC_C_BIG] ? swap(mem_rdata) : mem_rdata;
		`JDHC_A_CPAREA: rdv = cpa_ff;
		`JDHC_A_NVCMD:  rdv = 32'h0;
		default:        rdok = 1'b0;
		endcase
	end

	// axi4-lite read channel, one cycle answer
	assign s_axi_arready = ~r_ff;
	assign s_axi_rvalid = r_ff;
	assign s_axi_rdata = rd_ff;
	assign s_axi_rresp = rerr_ff ? `JDHC_RESP_ERR : `JDHC_RESP_OK;
	always @(posedge aclk) begin
		if (!aresetn) begin
			r_ff <= 1'b0;
			rerr_ff <= 1'b0;
			rd_ff <= 32'h0;
		end else if (s_axi_arvalid && !r_ff) begin
			r_ff <= 1'b1;
			rd_ff <= rdv;
			rerr_ff <= ~rdok;
		end else if (r_ff && s_axi_rready) begin
			r_ff <= 1'b0;
		end
	end

	// configuration registers and nonvolatile core type
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= 12'h000;
			cpa_ff <= `JDHC_CPAREA_RST;
			memw_ff <= 32'h0;
			tms_ff <= 32'h0;
			tdi_ff <= 32'h0;
			len_ff <= 6'h00;
			nvs_ff <= 1'b0;
		end else begin
			nvs_ff <= wr_nv & wv[0];
			if (wr_ctrl)
				ctrl_ff <= {(wv[`JDHC_C_PROC] > `JDHC_PROC_MAX) ? ctrl_ff[`JDHC_C_PROC] :
					wv[`JDHC_C_PROC], 2'h0, wv[5:0]};
			else if (wr_nv && wv[1] && nv_load_data <= `JDHC_PROC_MAX)
				ctrl_ff[`JDHC_C_PROC] <= nv_load_data;
			if (do_wr && awa_ff == `JDHC_A_CPAREA)
				cpa_ff <= merge(cpa_ff, wd_ff, ws_ff);
			if (do_wr && awa_ff == `JDHC_A_MEMW)
				memw_ff <= merge(memw_ff, wd_ff, ws_ff);
			if (do_wr && awa_ff == `JDHC_A_TMS && !busy_ff)
				tms_ff <= merge(tms_ff, wd_ff, ws_ff);
			if (do_wr && awa_ff == `JDHC_A_TDI && !busy_ff)
				tdi_ff <= merge(tdi_ff, wd_ff, ws_ff);
			if (wr_shf && !busy_ff)
				len_ff <= wv[5:0];
		end
	end
	assign nv_save = nvs_ff;
	assign nv_save_data = ctrl_ff[`JDHC_C_PROC];
	assign mem_wdata = ctrl_ff[`JDHC_C_BIG] ? swap(memw_ff) : memw_ff;
	assign scratch_base = cpa_ff;
	assign scratch_last = cpa_ff + `JDHC_SCR_LEN - 32'h1;

	// smallest half period whose rate does not exceed the request
	always @(posedge aclk) begin
		if (!aresetn) begin
			khz_ff <= `JDHC_SPEED_RST;
			calc_ff <= 8'h01;
			half_ff <= 8'h02;
			calc_busy_ff <= 1'b0;
		end else if (wr_spd && !busy_ff) begin
			khz_ff <= req_khz;
			calc_ff <= 8'h01;
			calc_busy_ff <= 1'b1;
		end else if (calc_busy_ff) begin
			if (prod >= {1'b0, `JDHC_CLK_KHZ}) begin
				half_ff <= calc_ff;
				calc_busy_ff <= 1'b0;
			end else begin
				calc_ff <= calc_ff + 8'h01;
			end
		end
	end

	// scan engine: bits change on falling tck, tdo taken at rise or late at fall
	assign tck = tck_ff;
	assign tms = tms_ff[bit_ff[4:0]];
	assign tdi = tdi_ff[bit_ff[4:0]];
	always @(posedge aclk) begin
		if (!aresetn) begin
			busy_ff <= 1'b0;
			tck_ff <= 1'b0;
			cnt_ff <= 8'h00;
			bit_ff <= 6'h00;
			tdo_ff <= 32'h0;
		end else if (!busy_ff) begin
			tck_ff <= 1'b0;
			cnt_ff <= 8'h00;
			if (wr_shf && !calc_busy_ff && wv[5:0] != 6'h00 && wv[5:0] <= 6'h20) begin
				busy_ff <= 1'b1;
				bit_ff <= 6'h00;
			end
		end else begin
			cnt_ff <= tick ? 8'h00 : cnt_ff + 8'h01;
			if (tick) begin
				tck_ff <= ~tck_ff;
				if (tck_ff == ctrl_ff[`JDHC_C_LATE])
					tdo_ff[bit_ff[4:0]] <= tdo;
				if (tck_ff) begin
					bit_ff <= bit_ff + 6'h01;
					if (bit_ff + 6'h01 == len_ff)
						busy_ff <= 1'b0;
				end
			end
		end
	end

	// access phase sequencing; software marks each phase done, and the acknowledge also ends the halt phase
	always @* begin
		nxt_ph = ph_ff;
		case (ph_ff)
		P_IDLE: if (op_go && halting_op && !reject)
			nxt_ph = running ? P_HALT : (opc == `JDHC_OP_CP ? P_SAVE : P_ACC);
		P_HALT: if (ack_s || op_adv)
			nxt_ph = cp_ff ? P_SAVE : P_ACC;
		P_SAVE: if (op_adv)
			nxt_ph = P_ACC;
		P_ACC:  if (op_adv)
			nxt_ph = cp_ff ? P_REST : (resume_ff ? P_RES : P_IDLE);
		P_REST: if (op_adv)
			nxt_ph = resume_ff ? P_RES : P_IDLE;
		P_RES:  if (op_adv)
			nxt_ph = P_IDLE;
		default: nxt_ph = P_IDLE;
		endcase
	end
	assign op_phase = ph_ff;

	// phase state, halt tracking, reject flag and request line
	always @(posedge aclk) begin
		if (!aresetn) begin
			ph_ff <= P_IDLE;
			cp_ff <= 1'b0;
			resume_ff <= 1'b0;
			halted_ff <= 1'b0;
			rj_ff <= 1'b0;
			req_ff <= 1'b0;
		end else begin
			ph_ff <= nxt_ph;
			if (op_go) begin
				cp_ff <= opc == `JDHC_OP_CP;
				resume_ff <= running;
			end
			if (op_go && opc == `JDHC_OP_BRK)
				halted_ff <= 1'b1;
			else if (op_go && (opc == `JDHC_OP_RUN || opc == `JDHC_OP_STEP))
				halted_ff <= 1'b0;
			else if (ph_ff == P_HALT && nxt_ph != P_HALT)
				halted_ff <= 1'b1;
			else if (ph_ff == P_RES && nxt_ph == P_IDLE)
				halted_ff <= 1'b0;
			// set wins over the write-one clear
			rj_ff <= reject | (rj_ff & ~(wr_stat & wv[`JDHC_S_RJ]));
			// a write that drops the line clears the request on the same edge
			req_ff <= req_on & ~(wr_ctrl & ~wv[`JDHC_C_REQ]) & ~halted & (req_ff | break_in |
				(op_go && opc == `JDHC_OP_BRK) | (ph_ff == P_HALT));
		end
	end
	assign debug_state_request = req_ff;
	assign debug_state_request_oe = req_on;
	assign trigger_out = ack_s;

	// debug channel poll timer
	always @(posedge aclk) begin
		if (!aresetn || !ctrl_ff[`JDHC_C_POLL]) begin
			poll_ff <= 16'h0000;
			poll_tick_ff <= 1'b0;
		end else begin
			poll_tick_ff <= poll_ff == POLL_CYCLES - 16'h0001;
			poll_ff <= (poll_ff == POLL_CYCLES - 16'h0001) ? 16'h0000 : poll_ff + 16'h0001;
		end
	end
	assign comms_poll_tick = poll_tick_ff;
endmodule // jdhc_core

// ===== design/jdhc_defs.vh
// constants for the jtag debug host configuration block
`ifndef JDHC_DEFS_VH
`define JDHC_DEFS_VH
// register byte offsets
`define JDHC_A_CTRL   6'h00
`define JDHC_A_SPEED  6'h04
`define JDHC_A_TMS    6'h08
`define JDHC_A_TDI    6'h0c
`define JDHC_A_SHIFT  6'h10
`define JDHC_A_TDO    6'h14
`define JDHC_A_STAT   6'h18
`define JDHC_A_OP     6'h1c
`define JDHC_A_MEMW   6'h20
`define JDHC_A_MEMR   6'h24
`define JDHC_A_CPAREA 6'h28
`define JDHC_A_NVCMD  6'h2c
// control fields
`define JDHC_C_LATE   0
`define JDHC_C_ACK    1
`define JDHC_C_REQ    2
`define JDHC_C_RRT    3
`define JDHC_C_BIG    4
`define JDHC_C_POLL   5
`define JDHC_C_PROC   11:8
`define JDHC_PROC_MAX 4'hb
// status and operation fields
`define JDHC_S_RJ     3
`define JDHC_OP_DONE  31
// operations
`define JDHC_OP_BRK   3'h0
`define JDHC_OP_RUN   3'h2
`define JDHC_OP_STEP  3'h3
`define JDHC_OP_MEM   3'h4
`define JDHC_OP_CP    3'h6
// reset values and limits
`define JDHC_SPEED_RST  16'h2710
`define JDHC_CPAREA_RST 32'h00000020
`define JDHC_SCR_LEN    32'h00000050
`define JDHC_KHZ_MIN    16'h0187
`define JDHC_KHZ_STD    16'h2710
`define JDHC_KHZ_LATE   16'h9c40
// system clock in khz
`define JDHC_CLK_KHZ    24'h009c40
`define JDHC_RESP_OK    2'h0
`define JDHC_RESP_ERR   2'h2
`endif

// ===== test/jdhc_core_sva.sv
// assertion checker for the jtag debug host block
`timescale 1ns/10ps
module jdhc_core_sva (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_awready,
	input wire        s_axi_bvalid,
	input wire        debug_state_request,
	input wire        debug_state_request_oe,
	input wire        debug_ack,
	input wire        trigger_out,
	input wire        comms_poll_tick,
	input wire [31:0] scratch_base,
	input wire [31:0] scratch_last,
	input wire [5:0]  op_phase,
	input wire        nv_save
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// idle phase being left
	sequence leave_idle;
		op_phase == 6'h01 ##1 op_phase != 6'h01;
	endsequence
	req_absent_a: assert property (!debug_state_request_oe |-> !debug_state_request)
		else $error("request raised while absent");
	trig_gate_a: assert property (trigger_out |-> debug_ack)
		else $error("trigger without acknowledge");
	scratch_span_a: assert property (scratch_last == scratch_base + 32'h0000004f)
		else $error("scratch block not 80 bytes");
	poll_pulse_a: assert property (comms_poll_tick |=> !comms_poll_tick)
		else $error("poll tick longer than one cycle");
	nv_pulse_a: assert property (nv_save |=> !nv_save)
		else $error("save pulse longer than one cycle");
	phase_onehot_a: assert property ($onehot(op_phase))
		else $error("phase not one-hot");
	phase_start_a: assert property (leave_idle |-> op_phase inside {6'h02, 6'h04, 6'h08})
		else $error("bad first phase");
	b_blocks_aw_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken during response");
endmodule // jdhc_core_sva
bind jdhc_core jdhc_core_sva u_sva (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid,
	.debug_state_request, .debug_state_request_oe, .debug_ack, .trigger_out,
	.comms_poll_tick, .scratch_base, .scratch_last, .op_phase, .nv_save);

// ===== test/jdhc_target.sv
// target model: one scan cell, debug state and a memory word
`timescale 1ns/10ps
module jdhc_target (
	input  wire        tck,
	input  wire        tdi,
	output reg         tdo,
	input  wire        debug_state_request,
	input  wire        debug_state_request_oe,
	input  wire        resume,
	output reg         debug_ack,
	output wire [31:0] mem_rdata
);
	reg cell_ff;
	assign mem_rdata = 32'ha1b2c3d4;
	initial begin
		tdo = 1'b0;
		cell_ff = 1'b0;
		debug_ack = 1'b0;
	end
	// tdi taken on the rising scan edge
	always @(posedge tck) cell_ff <= tdi;
	// tdo moves on the falling scan edge
	always @(negedge tck) tdo <= cell_ff;
	// enter debug state on a driven request
	always @(posedge debug_state_request or posedge resume)
		debug_ack <= resume ? 1'b0 : debug_state_request_oe;
endmodule // jdhc_target

// ===== test/jdhc_core_tb.sv
// self-checking bench for the jtag debug host block
`timescale 1ns/10ps
`include "jdhc_defs.vh"
module jdhc_core_tb;
	logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
	logic        break_in = 0, resume = 0;
	logic [5:0]  awaddr = 0, araddr = 0, seen = 0;
	logic [31:0] wdata = 0, rdat;
	logic [3:0]  nv_load = 0;
	logic [1:0]  rsp;
	logic [15:0] sreq [4] = '{16'h0064, 16'h1b58, 16'h2711, 16'h9c41};
	logic [23:0] sexp [4] = '{24'h340187, 24'h031b58, 24'h022710, 24'h019c40};
	int          miscompares = 0, checked = 0, n, sawreq = 0, ticks = 0;
	wire         awready, wready, bvalid, arready, rvalid, tck, tms, tdi, tdo;
	wire         req, req_oe, ack, trig, tick, nv_save;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata, mem_wdata, mem_rdata, sbase;
	wire [5:0]   phase;
	wire [3:0]   nv_data;
	always #12.5 aclk = ~aclk;
	jdhc_core #(.POLL_CYCLES(16'h0004)) DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .tck(tck),
		.tms(tms),
		.tdi(tdi), .tdo(tdo), .debug_state_request(req), .debug_state_request_oe(req_oe),
		.debug_ack(ack), .break_in(break_in), .trigger_out(trig), .comms_poll_tick(tick),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .scratch_base(sbase),
		.scratch_last(), .op_phase(phase), .nv_save(nv_save), .nv_save_data(nv_data),
		.nv_load_data(nv_load));
	jdhc_target u_tgt (.tck(tck), .tdi(tdi), .tdo(tdo), .debug_state_request(req),
		.debug_state_request_oe(req_oe), .resume(resume), .debug_ack(ack),
		.mem_rdata(mem_rdata));
	// note phases visited and request pulses
	always @(posedge aclk) begin
		if (aresetn) seen <= seen | phase; // phase is unknown before the first reset edge
		if (req === 1'b1) sawreq <= 1;
	end
	task wr(input [5:0] a, input [31:0] d);
		begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1;
			wvalid <= 1;
			do begin
				@(posedge aclk);
				if (awready) awvalid <= 0;
				if (wready) wvalid <= 0;
			end while (bvalid !== 1'b1);
			rsp = bresp;
		end
	endtask
	task rd(input [5:0] a);
		begin
			araddr <= a;
			arvalid <= 1;
			do begin
				@(posedge aclk);
				if (arready) arvalid <= 0;
			end while (rvalid !== 1'b1);
			rdat = rdata;
			rsp = rresp;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checked++;
			if (got !== exp) begin
				miscompares++;
				$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task rchk(input [5:0] a, input [31:0] m, input [31:0] exp);
		begin
			rd(a);
			chk(rdat & m, exp);
		end
	endtask
	task fin(input string s);
		$display("test %s finished", s);
	endtask
	task idle(input int b);
		do rd(`JDHC_A_STAT); while (rdat[b] !== 1'b0);
	endtask
	task results;
		begin
			$display("checked %0d miscompares %0d", checked, miscompares);
			if (miscompares == 0 && checked > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		results;
	end
	// main sequence
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		rchk(`JDHC_A_CTRL, 32'hffffffff, 32'h0);
		chk(sbase, 32'h20);
		wr(`JDHC_A_CPAREA, 32'h40);
		rchk(`JDHC_A_CPAREA, 32'hffffffff, 32'h40);
		rd(6'h30);
		chk(rsp, 2'h2);
		wr(`JDHC_A_TDO, 32'h1);
		chk(rsp, 2'h2);
		fin("registers");
		for (n = 0; n < 4; n++) begin
			wr(`JDHC_A_CTRL, {31'h0, n == 3});
			wr(`JDHC_A_SPEED, {16'h0, sreq[n]});
			idle(1);
			rchk(`JDHC_A_SPEED, 32'h00ffffff, {8'h0, sexp[n]});
		end
		fin("speed");
		wr(`JDHC_A_CTRL, 32'h0);
		wr(`JDHC_A_SPEED, 32'h2710);
		idle(1);
		wr(`JDHC_A_TDI, 32'h3c5a96e1);
		repeat (2) begin
			wr(`JDHC_A_SHIFT, 32'h20);
			idle(0);
		end
		rchk(`JDHC_A_TDO, 32'hffffffff, 32'h78b52dc2);
		wr(`JDHC_A_CTRL, 32'h1);
		wr(`JDHC_A_SHIFT, 32'h20);
		idle(0);
		rchk(`JDHC_A_TDO, 32'hffffffff, 32'h78b52dc2);
		wr(`JDHC_A_TMS, 32'h1);
		chk(tms, 1'b1);
		fin("scan");
		wr(`JDHC_A_MEMW, 32'h11223344);
		rchk(`JDHC_A_MEMR, 32'hffffffff, 32'ha1b2c3d4);
		chk(mem_wdata, 32'h11223344);
		wr(`JDHC_A_CTRL, 32'h10);
		rchk(`JDHC_A_MEMR, 32'hffffffff, 32'hd4c3b2a1);
		chk(mem_wdata, 32'h44332211);
		fin("endian");
		for (n = 0; n < 2; n++) begin
			wr(`JDHC_A_CTRL, n ? 32'h4 : 32'h0);
			break_in <= 1;
			@(posedge aclk);
			break_in <= 0;
			repeat (4) @(posedge aclk);
			chk({req_oe, sawreq[0]}, n ? 2'h3 : 2'h0);
		end
		chk(trig, 1'b0);
		wr(`JDHC_A_CTRL, 32'h6);
		chk(trig, 1'b1);
		resume <= 1;
		fin("sideband");
		wr(`JDHC_A_CTRL, 32'h8);
		wr(`JDHC_A_OP, 32'h2);
		wr(`JDHC_A_OP, 32'h4);
		rchk(`JDHC_A_STAT, 32'h8, 32'h8);
		chk(seen, 6'h01);
		wr(`JDHC_A_STAT, 32'h8);
		rchk(`JDHC_A_STAT, 32'h8, 32'h0);
		wr(`JDHC_A_CTRL, 32'h0);
		wr(`JDHC_A_OP, 32'h6);
		@(posedge aclk);
		for (n = 0; n < 10 && phase !== 6'h01; n++) wr(`JDHC_A_OP, 32'h80000000);
		chk(seen, 6'h3f);
		fin("operations");
		for (n = 0; n < 2; n++) begin
			wr(`JDHC_A_CTRL, n ? 32'h0 : 32'h20);
			ticks = 0;
			repeat (40) @(posedge aclk) ticks += tick;
			chk(ticks, n ? 0 : 10);
		end
		fin("polling");
		wr(`JDHC_A_CTRL, 32'h500);
		wr(`JDHC_A_NVCMD, 32'h1);
		chk(nv_save, 1'b1);
		chk(nv_data, 4'h5);
		nv_load <= 4'h7;
		wr(`JDHC_A_NVCMD, 32'h2);
		rchk(`JDHC_A_CTRL, 32'hf00, 32'h700);
		wr(`JDHC_A_CTRL, 32'hc00);
		rchk(`JDHC_A_CTRL, 32'hf00, 32'h700);
		fin("core type");
		results;
	end
endmodule // jdhc_core_tb
